// File: rtl/sys_config_regs.sv
// system configuration register bank on an ahb-lite slave port
// assumes single word transfers, one clock, synchronous inputs
//
// What this block does
// [RL1] two-bit remap selects memory at zero
// [RL2] remap field loaded from boot levels
// [RL3] six float exception interrupt enables on top
// [RL4] battery monitor bit closes converter switch
// [RL5] second i2c fast plus ored per pin
// [RL6] first i2c fast plus ored per pin
// [RL7] four port b pin fast plus enables
// [RL8] timer18 requests steer to channel five
// [RL9] timer7 requests steer to channel four
// [RL10] timer6 requests steer to channel three
// [RL11] timer17 requests steer channel one/two
// [RL12] four-bit code picks source port
// [RL13] four select registers, four lines each
// [RL14] parity flag set by hardware, write-one clears
// [RL15] voltage lock sticky, freezes detector fields
// [RL16] parity lock sticky, feeds timer break
// [RL17] hang lock sticky, feeds timer break
// [RL18] port f and high b limited
// [RL19] software keeps reserved bits at reset
// [RL20] break is or of locked sources
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module sys_config_regs (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // boot straps
    input wire logic boot_select_pin,
    input wire logic boot_option_bit,
    // fault sources and sram error event
    input wire cfg_regs_pkg::fault_src_s fault_src,
    // configuration outputs
    output logic [cfg_regs_pkg::REMAP_W-1:0] mem_remap,
    output logic [cfg_regs_pkg::FPIE_W-1:0] float_exception_irq_enables,
    output logic battery_monitor_enable,
    output logic [cfg_regs_pkg::PINFP_W-1:0] pin_fast_plus_drive,
    output logic first_i2c_fast_plus,
    output logic second_i2c_fast_plus,
    output cfg_regs_pkg::dma_route_s dma_route,
    output logic detector_fields_locked,
    output logic timer_break,
    // external line selection
    input wire logic [cfg_regs_pkg::LINES-1:0] port_a,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_b,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_c,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_d,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_e,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_f,
    output logic [cfg_regs_pkg::LINES-1:0] ext_line
);
    import cfg_regs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] cfg_one_q; // config one, writable bits only
    logic [31:0] cfg_one_d;
    logic [SEL_REGS*16-1:0] sel_q; // all four select registers
    logic [SEL_REGS*16-1:0] sel_d;
    logic [2:0] locks_q; // sticky lock bits
    logic [2:0] locks_d;
    logic pef_q; // sram parity flag
    logic pef_d;
    logic strap_pend_q; // straps still to be caught after release
    ahb_phase_s phase_q; // accepted address phase
    ahb_phase_s phase_d;
    logic [31:0] rdata_q; // registered read data
    logic [31:0] rdata_d;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // word index of a byte offset, used by several decodes
    function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
        word_of = a >> ADDR_LSB;
    endfunction : word_of

    wire take = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire wr = phase_q.valid & phase_q.write;
    wire [ADDR_W-1:0] wa = phase_q.addr;
    wire hit_one = wr & (wa == OFS_CONFIG_ONE);
    wire hit_two = wr & (wa == OFS_CONFIG_TWO);
    wire in_sel = (wa >= OFS_SELECT_ONE) && (wa <= OFS_SELECT_FOUR);
    wire [ADDR_W-1:0] sel_idx = word_of(wa) - word_of(OFS_SELECT_ONE);
    wire [ADDR_W-1:0] ra = haddr[ADDR_W-1:0];
    wire r_sel = (ra >= OFS_SELECT_ONE) && (ra <= OFS_SELECT_FOUR);
    wire [ADDR_W-1:0] r_idx = word_of(ra) - word_of(OFS_SELECT_ONE);

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    // data phase stores the write; reserved bits never store (software
    // is expected to keep them at zero anyway)
    always_comb begin
        cfg_one_d = cfg_one_q;
        sel_d = sel_q;
        locks_d = locks_q;
        pef_d = pef_q;
        // [RL1] software overrides remap
        if (hit_one) begin
            cfg_one_d = hwdata & CONFIG_ONE_MASK;
        end
        // [RL13] four lines per register
        if (wr && in_sel) begin
            sel_d[sel_idx[1:0]*16 +: 16] = hwdata[15:0] & SEL_MASK;
        end
        if (hit_two) begin
            // [RL15] locks only set
            locks_d = locks_q | hwdata[VDET_BIT:HANG_BIT];
            // [RL14] write one clears
            if (hwdata[PEF_BIT]) begin
                pef_d = 1'b0;
            end
        end
        // [RL14] hardware set wins
        if (fault_src.sram_parity) begin
            pef_d = 1'b1;
        end
    end

    // read mux for the address phase
    always_comb begin
        rdata_d = ZERO_WORD;
        if (ra == OFS_CONFIG_ONE) begin
            rdata_d = cfg_one_q;
        end else if (r_sel) begin
            rdata_d[15:0] = sel_q[r_idx[1:0]*16 +: 16];
        end else if (ra == OFS_CONFIG_TWO) begin
            rdata_d[PEF_BIT] = pef_q;
            rdata_d[VDET_BIT:HANG_BIT] = locks_q;
        end
    end

    always_comb begin
        phase_d.valid = take;
        phase_d.write = hwrite;
        phase_d.addr = ra;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // config state; remap is caught from the straps in the first
    // enabled cycle after release so reset only loads constants
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_one_q <= ZERO_WORD;
            strap_pend_q <= 1'b1;
        end else if (clk_en) begin
            cfg_one_q <= cfg_one_d;
            // [RL2] boot level load
            if (strap_pend_q) begin
                cfg_one_q[REMAP_LSB +: REMAP_W] <= {boot_option_bit, boot_select_pin};
                strap_pend_q <= 1'b0;
            end
        end
    end

    // select registers, locks and flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q <= '0;
            locks_q <= 3'h0;
            pef_q <= 1'b0;
        end else if (clk_en) begin
            sel_q <= sel_d;
            locks_q <= locks_d;
            pef_q <= pef_d;
        end
    end

    // bus pipeline
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= '0;
            rdata_q <= ZERO_WORD;
        end else if (clk_en) begin
            phase_q <= phase_d;
            if (take && !hwrite) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // zero wait state, always okay; hsize is word only by contract
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    // [RL1] remap output
    assign mem_remap = cfg_one_q[REMAP_LSB +: REMAP_W];
    // [RL3] float enables
    assign float_exception_irq_enables = cfg_one_q[FPIE_LSB +: FPIE_W];
    // [RL4] battery switch
    assign battery_monitor_enable = cfg_one_q[BATMON_BIT];
    assign first_i2c_fast_plus = cfg_one_q[I2C1FP_BIT];
    assign second_i2c_fast_plus = cfg_one_q[I2C2FP_BIT];
    // [RL7] per pin drive; [RL5] [RL6] controller bits ored in,
    // port b pins 6..9 carry either controller via alternate function
    assign pin_fast_plus_drive = cfg_one_q[PINFP_LSB +: PINFP_W]
        | {PINFP_W{first_i2c_fast_plus | second_i2c_fast_plus}};
    // [RL8] timer18 steering
    assign dma_route.t18_to_first = cfg_one_q[DMA18_BIT];
    // [RL9] timer7 steering
    assign dma_route.t7_to_first = cfg_one_q[DMA7_BIT];
    // [RL10] timer6 steering
    assign dma_route.t6_to_first = cfg_one_q[DMA6_BIT];
    // [RL11] timer17 steering
    assign dma_route.t17_to_ch2 = cfg_one_q[DMA17_BIT];
    // [RL15] detector fields frozen
    assign detector_fields_locked = locks_q[VDET_BIT];
    // [RL20] or of locked sources
    // [RL16] [RL17] parity and hang
    assign timer_break = (locks_q[VDET_BIT] & fault_src.vdet_irq)
        | (locks_q[PAR_BIT] & fault_src.sram_parity)
        | (locks_q[HANG_BIT] & fault_src.core_hang);

    // ----------------------------------------------------------------
    // external line multiplexer
    // ----------------------------------------------------------------
    ext_line_mux u_mux (
        .sel(sel_q),
        .port_a(port_a),
        .port_b(port_b),
        .port_c(port_c),
        .port_d(port_d),
        .port_e(port_e),
        .port_f(port_f),
        .ext_line(ext_line)
    );
endmodule : sys_config_regs

// File: pkg/cfg_regs_pkg.sv
// package for the system configuration register bank
// assumes one 10 MHz clock, word-only AHB-Lite accesses
package cfg_regs_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG_ONE = 8'h00;
    localparam logic [7:0] OFS_SELECT_ONE = 8'h08;
    localparam logic [7:0] OFS_SELECT_TWO = 8'h0c;
    localparam logic [7:0] OFS_SELECT_THREE = 8'h10;
    localparam logic [7:0] OFS_SELECT_FOUR = 8'h14;
    localparam logic [7:0] OFS_CONFIG_TWO = 8'h18;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 8;
    // ----------------------------------------------------------------
    // config one fields
    // ----------------------------------------------------------------
    localparam int REMAP_LSB = 0;
    localparam int REMAP_W = 2;
    localparam int DMA17_BIT = 12;
    localparam int DMA6_BIT = 13;
    localparam int DMA7_BIT = 14;
    localparam int DMA18_BIT = 15;
    localparam int PINFP_LSB = 16;
    localparam int PINFP_W = 4;
    localparam int I2C1FP_BIT = 20;
    localparam int I2C2FP_BIT = 21;
    localparam int BATMON_BIT = 24;
    localparam int FPIE_LSB = 26;
    localparam int FPIE_W = 6;
    // writable mask of config one
    localparam logic [31:0] CONFIG_ONE_MASK = 32'hfd3f_f003;
    // ----------------------------------------------------------------
    // select registers and config two
    // ----------------------------------------------------------------
    localparam int SEL_FIELDS = 4;
    localparam int SEL_W = 4;
    localparam int SEL_REGS = 4;
    localparam int LINES = 16;
    localparam logic [15:0] SEL_MASK = 16'hffff;
    localparam int HANG_BIT = 0;
    localparam int PAR_BIT = 1;
    localparam int VDET_BIT = 2;
    localparam int PEF_BIT = 8;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // ----------------------------------------------------------------
    // port source codes
    // ----------------------------------------------------------------
    localparam logic [3:0] SRC_A = 4'h0;
    localparam logic [3:0] SRC_B = 4'h1;
    localparam logic [3:0] SRC_F = 4'h5;
    // lines that may take port f
    localparam logic [15:0] PORT_F_LINES = 16'h06d7;
    // lines on the last register that may take port b
    localparam logic [15:0] PORT_B_HIGH = 16'hc000;
    // ----------------------------------------------------------------
    // ahb encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;

    // pending data phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_phase_s;

    // fault sources towards the timer break
    typedef struct packed {
        logic vdet_irq;
        logic sram_parity;
        logic core_hang;
    } fault_src_s;

    // dma steering outputs
    typedef struct packed {
        logic t18_to_first;
        logic t7_to_first;
        logic t6_to_first;
        logic t17_to_ch2;
    } dma_route_s;
endpackage : cfg_regs_pkg

// File: rtl/ext_line_mux.sv
// external interrupt line source selector, one port per line
// assumes port inputs already synchronous to mclk
`timescale 1ns/100ps
module ext_line_mux (
    input wire logic [cfg_regs_pkg::LINES*cfg_regs_pkg::SEL_W-1:0] sel,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_a,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_b,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_c,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_d,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_e,
    input wire logic [cfg_regs_pkg::LINES-1:0] port_f,
    output logic [cfg_regs_pkg::LINES-1:0] ext_line
);
    import cfg_regs_pkg::*;

    // ----------------------------------------------------------------
    // per line selection
    // ----------------------------------------------------------------
    // reserved codes and unusable port/line pairs give a quiet line
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            // [RL12] code to port
            unique case (sel[i*SEL_W +: SEL_W])
                4'h0: ext_line[i] = port_a[i];
                // [RL18] port b limits high
                4'h1: ext_line[i] = port_b[i] & (i < 12 || PORT_B_HIGH[i]);
                4'h2: ext_line[i] = port_c[i];
                4'h3: ext_line[i] = port_d[i];
                4'h4: ext_line[i] = port_e[i];
                // [RL18] port f limited lines
                4'h5: ext_line[i] = port_f[i] & PORT_F_LINES[i];
                default: ext_line[i] = 1'b0;
            endcase
        end
    end
endmodule : ext_line_mux

// File: sim/sys_config_regs_asserts.sv
// checker for the configuration bank, sees top ports only
// assumes the bank is bound below and runs on mclk alone
`timescale 1ns/100ps
module cfg_bank_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic boot_select_pin,
    input wire logic boot_option_bit,
    input wire cfg_regs_pkg::fault_src_s fault_src,
    input wire logic [1:0] mem_remap,
    input wire logic [5:0] float_exception_irq_enables,
    input wire logic battery_monitor_enable,
    input wire logic [3:0] pin_fast_plus_drive,
    input wire logic first_i2c_fast_plus,
    input wire logic second_i2c_fast_plus,
    input wire cfg_regs_pkg::dma_route_s dma_route,
    input wire logic detector_fields_locked,
    input wire logic timer_break
);
    import cfg_regs_pkg::*;
    // accepted address phase towards config one
    wire take0 = hsel && hready && htrans[1] && clk_en && (haddr == 32'h0);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_wr1;
        take0 && hwrite ##1 clk_en |=> mem_remap == $past(hwdata[1:0]) &&
            float_exception_irq_enables == $past(hwdata[31:26]) &&
            battery_monitor_enable == $past(hwdata[24]) && dma_route == $past(hwdata[15:12]);
    endproperty
    a_wr1: assert property (p_wr1) else $error("config one write lost");
    property p_rd1;
        take0 && !hwrite |=> hrdata[15:12] == dma_route && hrdata[1:0] == mem_remap &&
            hrdata[31:24] == {float_exception_irq_enables, 1'b0, battery_monitor_enable};
    endproperty
    a_rd1: assert property (p_rd1) else $error("config one read wrong");
    property p_boot;
        $past(sys_rst) && clk_en |=> mem_remap == $past({boot_option_bit, boot_select_pin});
    endproperty
    a_boot: assert property (p_boot) else $error("remap not from straps");
    property p_lock;
        detector_fields_locked |=> detector_fields_locked;
    endproperty
    a_lock: assert property (p_lock) else $error("detector lock dropped");
    property p_brk_on;
        detector_fields_locked && fault_src.vdet_irq |-> timer_break;
    endproperty
    a_brk_on: assert property (p_brk_on) else $error("break missing");
    property p_brk_off;
        fault_src == 3'b000 |-> !timer_break;
    endproperty
    a_brk_off: assert property (p_brk_off) else $error("break without source");
    property p_fmp;
        first_i2c_fast_plus || second_i2c_fast_plus |-> pin_fast_plus_drive == 4'hf;
    endproperty
    a_fmp: assert property (p_fmp) else $error("fast plus not ored");
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus answer not okay");
endmodule : cfg_bank_chk

bind sys_config_regs cfg_bank_chk u_chk (.mclk, .sys_rst, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .boot_select_pin,
    .boot_option_bit, .fault_src, .mem_remap, .float_exception_irq_enables,
    .battery_monitor_enable, .pin_fast_plus_drive, .first_i2c_fast_plus,
    .second_i2c_fast_plus, .dma_route, .detector_fields_locked, .timer_break);

// File: sim/system_config_registers_tb.sv
// self-checking bench for the configuration register bank
// assumes zero wait state answers and hready looped from hreadyout
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module system_config_registers_tb;
    import cfg_regs_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic boot_option_bit = 1'b1;
    logic boot_select_pin = 1'b0; // strap level, changed across the mid-run reset
    fault_src_s fault_src = 3'b000;
    logic [5:0][15:0] prt = '0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, battery_monitor_enable, first_i2c_fast_plus;
    logic second_i2c_fast_plus, detector_fields_locked, timer_break;
    logic [1:0] mem_remap;
    logic [5:0] float_exception_irq_enables;
    logic [3:0] pin_fast_plus_drive;
    dma_route_s dma_route;
    logic [15:0] ext_line;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    initial begin
        forever #50 mclk = ~mclk;
    end
    sys_config_regs dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .boot_select_pin(boot_select_pin), .boot_option_bit(boot_option_bit),
        .fault_src(fault_src),
        .mem_remap(mem_remap), .float_exception_irq_enables(float_exception_irq_enables),
        .battery_monitor_enable(battery_monitor_enable), .dma_route(dma_route),
        .pin_fast_plus_drive(pin_fast_plus_drive), .first_i2c_fast_plus(first_i2c_fast_plus),
        .second_i2c_fast_plus(second_i2c_fast_plus), .timer_break(timer_break),
        .detector_fields_locked(detector_fields_locked), .port_a(prt[0]), .port_b(prt[1]),
        .port_c(prt[2]), .port_d(prt[3]), .port_e(prt[4]), .port_f(prt[5]),
        .ext_line(ext_line));
    // one word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask : xfer
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK("rdata", e, rd)
    endtask : rchk
    // straps land in remap, all else reads zero, hole included
    task automatic t_reset;
        `CHK("remap", 2'b10, mem_remap)
        rchk(32'h0, 32'h2);
        for (int i = 1; i < 7; i++) rchk(32'(4 * i), 32'h0);
    endtask : t_reset
    // walk each writable config one bit and watch the outputs
    task automatic t_cfg1;
        logic [31:0] b;
        for (int i = 0; i < 32; i++) begin
            b = 32'h1 << i;
            if ((b & 32'hfd3f_f003) != 32'h0) begin
                xfer(1'b1, 32'h0, b);
                rchk(32'h0, b);
                `CHK("outs", {b[31:26], b[24], b[21:20], b[19:16] | {4{b[20] | b[21]}},
                    b[15:12], b[1:0]}, {float_exception_irq_enables, battery_monitor_enable,
                    second_i2c_fast_plus, first_i2c_fast_plus, pin_fast_plus_drive,
                    dma_route, mem_remap})
                `CHK("pins", b[19:16] | {4{b[20] | b[21]}}, pin_fast_plus_drive)
            end
        end
        // frozen bank ignores the write
        clk_en <= 1'b0;
        xfer(1'b1, 32'h0, 32'h0000_5001);
        clk_en <= 1'b1;
        rchk(32'h0, 32'h8000_0000);
    endtask : t_cfg1
    // every source code on every line, then one lone line
    task automatic t_sel;
        logic [15:0] e;
        for (int c = 0; c < 7; c++) begin
            prt <= 96'(16'hffff) << (16 * c);
            for (int r = 0; r < 4; r++) xfer(1'b1, 32'h8 + 32'(4 * r), {16'h0, {4{4'(c)}}});
            rchk(32'h14, {16'h0, {4{4'(c)}}});
            e = (c == 5) ? 16'h06d7 : (c == 1) ? 16'hcfff : (c < 5) ? 16'hffff : 16'h0;
            `CHK("ext_line", e, ext_line)
        end
        prt <= 96'(16'hffff) << 16;
        xfer(1'b1, 32'h10, 32'h10);
        rchk(32'h10, 32'h10);
        `CHK("ext_line", 16'h0200, ext_line)
    endtask : t_sel
    // parity flag, sticky locks, break gating, reset clears
    task automatic t_cfg2;
        @(posedge mclk);
        fault_src <= 3'b010;
        @(posedge mclk);
        fault_src <= 3'b000;
        rchk(32'h18, 32'h100);
        xfer(1'b1, 32'h18, 32'h0);
        rchk(32'h18, 32'h100);
        xfer(1'b1, 32'h18, 32'h100);
        rchk(32'h18, 32'h0);
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, 32'h18, 32'h1 << k);
            xfer(1'b1, 32'h18, 32'h0);
            rchk(32'h18, ((32'h2 << k) - 32'h1) | (k > 0 ? 32'h100 : 32'h0));
            `CHK("det_lock", k == 2, detector_fields_locked)
            for (int s = 0; s < 3; s++) begin
                fault_src <= 3'(1 << s);
                @(negedge mclk);
                `CHK("break", s <= k, timer_break)
                @(posedge mclk);
            end
            fault_src <= 3'b000;
        end
        // second reset with the other strap levels
        sys_rst <= 1'b1;
        boot_select_pin <= 1'b1;
        boot_option_bit <= 1'b0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rchk(32'h18, 32'h0);
        `CHK("det_lock", 1'b0, detector_fields_locked)
        `CHK("remap", 2'b01, mem_remap)
        rchk(32'h0, 32'h1);
    endtask : t_cfg2
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // hang guard, far above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        t_reset();
        t_cfg1();
        t_sel();
        t_cfg2();
        test_done();
    end
endmodule : system_config_registers_tb
